// >>> rtl/pbseq_top.sv
// Pushbutton on/off power sequencer with processor shutdown handshake.
//
// Behaviour
// [R1] Enable asserts after 32 ms continuous press.
// [R2] Turn-on press lengthened by extension parameter.
// [R3] Turn-off press needs 32 ms plus extension.
// [R4] Valid turn-off press pulls interrupt low.
// [R5] Timeout 1024 ms after interrupt releases enable.
// [R6] Kill low in power-down releases enable immediately.
// [R7] Blanking starts when enable is asserted.
// [R8] Blanking 512 ms ignores kill and pushbutton.
// [R9] Kill still low after blanking aborts power-on.
// [R10] Kill low during normal operation releases enable.
// [R11] Enable pin polarity chosen by variant parameter.
// [R12] Kill pulses of 30 us are recognised.
// [R13] Pushbutton ignored during lockout after release.
// [R14] Interrupt may be tied to kill externally.
// [R15] Button release restarts a running press debounce.
// [R16] Button release debounced 32 ms before new press.
// [R17] Lockout after enable release lasts 256 ms.
// [R18] Reset leaves enable released, interrupt inactive.
// [R19] Intervals counted in ticks of a slow timebase.
// [R20] Button and kill synchronised before use.
`timescale 1ns/1ps
`default_nettype none

module pbseq_top #(
	parameter int unsigned TICK_CYCLES = pbseq_pkg::TICK_CYCLES,
	parameter int unsigned ON_EXT_TICKS = pbseq_pkg::ON_EXT_DEFAULT,
	parameter int unsigned OFF_EXT_TICKS = pbseq_pkg::OFF_EXT_DEFAULT,
	parameter bit ENABLE_ACTIVE_LOW = 1'h0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic button_press_n,
	input wire logic kill_n,
	output var pbseq_pkg::pbseq_od_type enable_pin,
	output var pbseq_pkg::pbseq_od_type shutdown_int_pin,
	output logic power_on
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic pb_meta;
	logic pb_s;
	logic kill_meta;
	logic kill_s;

	// Kill is sampled every clock, so a 30 us pulse is far above need.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pb_meta <= pbseq_pkg::RST_SYNC;
			pb_s <= pbseq_pkg::RST_SYNC;
			kill_meta <= pbseq_pkg::RST_SYNC;
			kill_s <= pbseq_pkg::RST_SYNC;
		end else begin
			pb_meta <= button_press_n; // R20
			pb_s <= pb_meta;
			kill_meta <= kill_n; // R12
			kill_s <= kill_meta;
		end
	end

	// ************************************************************
	// Timebase and interval counter
	// ************************************************************
	pbseq_pkg::pbseq_state_type state;
	pbseq_pkg::pbseq_state_type next_state;
	logic [pbseq_pkg::PRESC_W-1:0] presc;
	logic [pbseq_pkg::CNT_W-1:0] ivl;
	logic [pbseq_pkg::CNT_W-1:0] target;
	wire logic tick;
	wire logic hold_restart;
	wire logic restart;
	wire logic done;

	function automatic logic [pbseq_pkg::CNT_W-1:0] ticks(
		input int unsigned n
	);
		ticks = n[pbseq_pkg::CNT_W-1:0];
	endfunction

	assign tick = (32'(presc) == TICK_CYCLES - 1);
	// A press during a release debounce starts the wait over.
	assign hold_restart = !pb_s &&
		(state == pbseq_pkg::ST_ON_REL || state == pbseq_pkg::ST_OFF_REL);
	assign restart = (state != next_state) || hold_restart; // R16
	assign done = (ivl >= target);

	assign target =
		(state == pbseq_pkg::ST_ON_DB) ?
			ticks(pbseq_pkg::DEBOUNCE_TICKS + ON_EXT_TICKS) : // R1 R2
		(state == pbseq_pkg::ST_OFF_DB) ?
			ticks(pbseq_pkg::DEBOUNCE_TICKS + OFF_EXT_TICKS) : // R3
		(state == pbseq_pkg::ST_BLANK) ?
			ticks(pbseq_pkg::BLANK_TICKS) : // R8
		(state == pbseq_pkg::ST_PDOWN) ?
			ticks(pbseq_pkg::PDOWN_TICKS) : // R5
		(state == pbseq_pkg::ST_LOCK) ?
			ticks(pbseq_pkg::LOCKOUT_TICKS) : // R17
			ticks(pbseq_pkg::DEBOUNCE_TICKS);

	// Clearing the prescaler on each restart makes every interval an
	// exact multiple of the tick rather than up to one tick short.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc <= '0;
			ivl <= '0;
		end else if (restart) begin
			presc <= '0;
			ivl <= '0;
		end else if (tick) begin // R19
			presc <= '0;
			ivl <= done ? ivl : ivl + 1'h1;
		end else begin
			presc <= presc + 1'h1;
		end
	end

	// ************************************************************
	// Sequencing state machine
	// ************************************************************
	always_comb begin
		next_state = state;
		unique case (state)
			pbseq_pkg::ST_IDLE: begin
				if (!pb_s) begin
					next_state = pbseq_pkg::ST_ON_DB;
				end
			end
			pbseq_pkg::ST_ON_DB: begin
				if (pb_s) begin
					next_state = pbseq_pkg::ST_IDLE; // R15
				end else if (done) begin
					next_state = pbseq_pkg::ST_BLANK; // R7
				end
			end
			pbseq_pkg::ST_BLANK: begin
				if (done) begin
					next_state = kill_s ? pbseq_pkg::ST_ON_REL :
						pbseq_pkg::ST_LOCK; // R9
				end
			end
			pbseq_pkg::ST_ON_REL: begin
				if (!kill_s) begin
					next_state = pbseq_pkg::ST_LOCK; // R10
				end else if (done) begin
					next_state = pbseq_pkg::ST_RUN;
				end
			end
			pbseq_pkg::ST_RUN: begin
				if (!kill_s) begin
					next_state = pbseq_pkg::ST_LOCK; // R10
				end else if (!pb_s) begin
					next_state = pbseq_pkg::ST_OFF_DB;
				end
			end
			pbseq_pkg::ST_OFF_DB: begin
				if (!kill_s) begin
					next_state = pbseq_pkg::ST_LOCK; // R10
				end else if (pb_s) begin
					next_state = pbseq_pkg::ST_RUN; // R15
				end else if (done) begin
					next_state = pbseq_pkg::ST_PDOWN; // R4
				end
			end
			pbseq_pkg::ST_PDOWN: begin
				// With the interrupt tied to kill this leaves at once.
				if (!kill_s || done) begin
					next_state = pbseq_pkg::ST_LOCK; // R5 R6 R14
				end
			end
			pbseq_pkg::ST_LOCK: begin
				if (done) begin
					next_state = pbseq_pkg::ST_OFF_REL; // R13
				end
			end
			pbseq_pkg::ST_OFF_REL: begin
				if (done) begin
					next_state = pbseq_pkg::ST_IDLE; // R16
				end
			end
			default: begin
				next_state = pbseq_pkg::ST_IDLE;
			end
		endcase
	end

	wire logic next_on;
	wire logic next_int;

	assign next_on = (next_state == pbseq_pkg::ST_BLANK) ||
		(next_state == pbseq_pkg::ST_ON_REL) ||
		(next_state == pbseq_pkg::ST_RUN) ||
		(next_state == pbseq_pkg::ST_OFF_DB) ||
		(next_state == pbseq_pkg::ST_PDOWN);
	assign next_int = (next_state == pbseq_pkg::ST_PDOWN);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= pbseq_pkg::ST_IDLE;
			power_on <= pbseq_pkg::RST_ENABLE_ON;
			enable_pin <= '{out: 1'h0, oe: !ENABLE_ACTIVE_LOW}; // R18
			shutdown_int_pin <= '{out: 1'h0, oe: 1'h0};
		end else begin
			state <= next_state;
			power_on <= next_on;
			// Open drain: the active-high variant asserts by letting go.
			enable_pin <= '{out: 1'h0,
				oe: ENABLE_ACTIVE_LOW ? next_on : !next_on}; // R11
			shutdown_int_pin <= '{out: 1'h0, oe: next_int}; // R4
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	logic [31:0] press_len;
	logic [31:0] pdown_len;
	logic [31:0] lock_len;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			press_len <= '0;
			pdown_len <= '0;
			lock_len <= '0;
		end else begin
			press_len <= pb_s ? 32'h0 : press_len + 32'h1;
			pdown_len <= (state == pbseq_pkg::ST_PDOWN) ?
				pdown_len + 32'h1 : 32'h0;
			lock_len <= (state == pbseq_pkg::ST_LOCK) ?
				lock_len + 32'h1 : 32'h0;
		end
	end

	sequence s_kill_low_run;
		state == pbseq_pkg::ST_RUN && !kill_s;
	endsequence

	sequence s_kill_low_pdown;
		state == pbseq_pkg::ST_PDOWN && !kill_s;
	endsequence

	sequence s_blank_end;
		state == pbseq_pkg::ST_BLANK && done;
	endsequence

	AST_ON_PRESS: assert property (@(posedge clk) disable iff (!nrst) // R1
		$rose(power_on) |-> press_len >=
			(pbseq_pkg::DEBOUNCE_TICKS + ON_EXT_TICKS) * TICK_CYCLES)
		else $error("Enable asserted after too short a press.");

	AST_OFF_PRESS: assert property (@(posedge clk) disable iff (!nrst) // R3
		$rose(shutdown_int_pin.oe) |-> press_len >=
			(pbseq_pkg::DEBOUNCE_TICKS + OFF_EXT_TICKS) * TICK_CYCLES)
		else $error("Interrupt raised after too short a press.");

	AST_INT_ENTRY: assert property (@(posedge clk) disable iff (!nrst) // R4
		$rose(state == pbseq_pkg::ST_PDOWN) |->
			shutdown_int_pin.oe && power_on)
		else $error("Interrupt not pulled low on turn-off press.");

	AST_PDOWN_LIMIT: assert property (@(posedge clk) disable iff (!nrst) // R5
		pdown_len <= pbseq_pkg::PDOWN_TICKS * TICK_CYCLES + 1)
		else $error("Power-down window overran its timeout.");

	AST_PDOWN_KILL: assert property (@(posedge clk) disable iff (!nrst) // R6
		s_kill_low_pdown |=> !power_on && !shutdown_int_pin.oe)
		else $error("Kill low in power-down did not release enable.");

	AST_BLANK_HOLD: assert property (@(posedge clk) disable iff (!nrst) // R8
		state == pbseq_pkg::ST_BLANK && !done |=> power_on)
		else $error("Enable dropped during blanking.");

	AST_BLANK_ABORT: assert property (@(posedge clk) disable iff (!nrst) // R9
		s_blank_end ##0 !kill_s |=> state == pbseq_pkg::ST_LOCK ##1
			enable_pin.oe == !ENABLE_ACTIVE_LOW)
		else $error("Kill low after blanking did not abort power-on.");

	AST_RUN_KILL: assert property (@(posedge clk) disable iff (!nrst) // R10
		s_kill_low_run |=> !power_on [*2])
		else $error("Kill low in normal operation kept enable.");

	AST_POLARITY: assert property (@(posedge clk) disable iff (!nrst) // R11
		enable_pin.oe == (ENABLE_ACTIVE_LOW ? power_on : !power_on))
		else $error("Enable pin polarity does not match variant.");

	AST_LOCKOUT: assert property (@(posedge clk) disable iff (!nrst) // R13
		$fell(power_on) |-> state == pbseq_pkg::ST_LOCK)
		else $error("Enable released without entering lockout.");

	AST_LOCK_LEN: assert property (@(posedge clk) disable iff (!nrst) // R17
		$fell(state == pbseq_pkg::ST_LOCK) |->
			$past(lock_len) + 1 == pbseq_pkg::LOCKOUT_TICKS * TICK_CYCLES
			+ 1)
		else $error("Lockout did not last its full period.");

	AST_DB_RESTART: assert property (@(posedge clk) disable iff (!nrst) // R15
		state == pbseq_pkg::ST_ON_DB && pb_s |=>
			state == pbseq_pkg::ST_IDLE && !power_on)
		else $error("Button release did not restart turn-on debounce.");

endmodule // pbseq_top

`default_nettype wire

// >>> rtl/pbseq_pkg.sv
// Constants and types shared by the pushbutton power sequencer.
`default_nettype none

package pbseq_pkg;

	// ************************************************************
	// Clock and timebase
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned TICK_US = 500;
	localparam int unsigned TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned PRESC_W = 15;
	localparam int unsigned CNT_W = 13;

	// ************************************************************
	// Intervals, printed times and their tick counts
	// ************************************************************
	localparam int unsigned DEBOUNCE_MS = 32;
	localparam int unsigned BLANK_MS = 512;
	localparam int unsigned PDOWN_MS = 1024;
	localparam int unsigned LOCKOUT_MS = 256;
	localparam int unsigned EXT_EXAMPLE_US = 11500;
	localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS * 1000 / TICK_US;
	localparam int unsigned BLANK_TICKS = BLANK_MS * 1000 / TICK_US;
	localparam int unsigned PDOWN_TICKS = PDOWN_MS * 1000 / TICK_US;
	localparam int unsigned LOCKOUT_TICKS = LOCKOUT_MS * 1000 / TICK_US;
	localparam int unsigned EXT_EXAMPLE_TICKS = EXT_EXAMPLE_US / TICK_US;
	localparam int unsigned ON_EXT_DEFAULT = 0;
	localparam int unsigned OFF_EXT_DEFAULT = 0;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic RST_ENABLE_ON = 1'h0;
	localparam logic RST_SYNC = 1'h1;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ON_DB = 9'h002,
		ST_BLANK = 9'h004,
		ST_ON_REL = 9'h008,
		ST_RUN = 9'h010,
		ST_OFF_DB = 9'h020,
		ST_PDOWN = 9'h040,
		ST_LOCK = 9'h080,
		ST_OFF_REL = 9'h100
	} pbseq_state_type;

	// Open-drain pin: oe high pulls the wire to out (always low).
	typedef struct packed {
		logic out;
		logic oe;
	} pbseq_od_type;

endpackage

`default_nettype wire

// >>> tb/pbseq_cpu_model.sv
// Processor and converter model on the far side of the sequencer.
`timescale 1ns/1ps
`default_nettype none

module pbseq_cpu_model #(
	parameter int ACK_CYCLES = 400
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic en_wire,
	input wire logic int_wire,
	input wire logic [1:0] mode,
	output logic kill_n
);
	// Mode 0 holds kill low, 1 answers the interrupt late, 2 never
	// answers it, 3 ties the interrupt line straight to kill.
	logic kill_q;
	int cnt;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			kill_q <= 1'h0;
			cnt <= 0;
		end else if (mode == 2'h0) begin
			kill_q <= 1'h0;
		end else if (!int_wire && mode == 2'h1) begin
			cnt <= cnt + 1;
			// Kill then stays low until power returns, far past 30 us.
			if (cnt == ACK_CYCLES) begin
				kill_q <= 1'h0;
			end
		end else if (en_wire) begin
			cnt <= 0;
			kill_q <= 1'h1;
		end
	end

	assign kill_n = (mode == 2'h3) ? int_wire : kill_q;
endmodule // pbseq_cpu_model
`default_nettype wire

// >>> tb/pushbutton_power_sequencer_bench.sv
// Self-checking bench for the pushbutton power sequencer.
`timescale 1ns/1ps
`default_nettype none

module pushbutton_power_sequencer_bench;
	localparam int T = 4;
	localparam int ON_EXT = 23;
	localparam int OFF_EXT = 5;
	localparam int DB_ON = (pbseq_pkg::DEBOUNCE_TICKS + ON_EXT) * T;
	localparam int DB_OFF = (pbseq_pkg::DEBOUNCE_TICKS + OFF_EXT) * T;
	localparam int BLANK = pbseq_pkg::BLANK_TICKS * T;
	localparam int PDOWN = pbseq_pkg::PDOWN_TICKS * T;
	localparam int LOCK = pbseq_pkg::LOCKOUT_TICKS * T;
	// A clean run needs just under half of this span.
	localparam int LIMIT = 2 * (5 * (LOCK + BLANK + 1000) + PDOWN);
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic button_press_n = 1'h1;
	logic [1:0] mode = 2'h1;
	logic kill_n, power_on, power_on_low, en_wire, int_wire;
	pbseq_pkg::pbseq_od_type enable_pin, shutdown_int_pin, enable_low;
	int failures = 0;
	int check_count = 0;

	always #12.5 clk = ~clk;

	pbseq_top #(.TICK_CYCLES(T), .ON_EXT_TICKS(ON_EXT),
		.OFF_EXT_TICKS(OFF_EXT), .ENABLE_ACTIVE_LOW(1'h0)) u_dut (
		.clk(clk), .nrst(nrst), .button_press_n(button_press_n),
		.kill_n(kill_n), .enable_pin(enable_pin),
		.shutdown_int_pin(shutdown_int_pin), .power_on(power_on));
	pbseq_top #(.TICK_CYCLES(T), .ON_EXT_TICKS(ON_EXT),
		.OFF_EXT_TICKS(OFF_EXT), .ENABLE_ACTIVE_LOW(1'h1)) u_dut_low (
		.clk(clk), .nrst(nrst), .button_press_n(button_press_n),
		.kill_n(kill_n), .enable_pin(enable_low),
		.shutdown_int_pin(), .power_on(power_on_low));

	// Both open-drain lines are pulled up outside the chip.
	assign en_wire = enable_pin.oe ? enable_pin.out : 1'h1;
	assign int_wire = shutdown_int_pin.oe ? shutdown_int_pin.out : 1'h1;

	pbseq_cpu_model u_cpu (.clk(clk), .nrst(nrst), .en_wire(en_wire),
		.int_wire(int_wire), .mode(mode), .kill_n(kill_n));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic tally_and_finish();
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check_bit(input logic act, input logic exp);
		check_count++;
		if (act !== exp) begin
			failures++;
			$display("[ERR] %0t got %0h exp %0h", $time, act, exp);
		end
	endtask

	task automatic check_span(input int act, input int lo, input int hi);
		check_count++;
		if (act < lo || act > hi) begin
			failures++;
			$display("[ERR] %0t got %0h exp %0h..%0h", $time, act, lo, hi);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic wait_for(input bit irq, input logic val, input int max,
		output int n);
		n = 0;
		while ((irq ? shutdown_int_pin.oe : power_on) !== val && n < max) begin
			tick(1);
			n++;
		end
	endtask

	task automatic check_pins(input logic on);
		check_bit(power_on, on);
		check_bit(enable_pin.oe, !on);
		check_bit(enable_low.oe, on);
		check_bit(power_on_low, on);
		check_bit(en_wire, on);
	endtask

	task automatic power_up();
		int n;
		button_press_n = 1'h0;
		wait_for(1'h0, 1'h1, DB_ON + 50, n);
		button_press_n = 1'h1;
		check_span(n, DB_ON, DB_ON + 6);
		check_pins(1'h1);
	endtask

	// Boots fully, then gives the press for turn-off and its count.
	task automatic boot_and_press(input logic [1:0] m, input bit irq,
		input int max, output int n);
		tick(LOCK + 300);
		mode = m;
		power_up();
		tick(BLANK + 400);
		check_pins(1'h1);
		button_press_n = 1'h0;
		wait_for(irq, irq, max, n);
		button_press_n = 1'h1;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic scn_abort();
		int n;
		mode = 2'h0;
		button_press_n = 1'h0;
		tick(300);
		button_press_n = 1'h1;
		tick(5);
		power_up();
		button_press_n = 1'h0;
		tick(DB_OFF + 20);
		button_press_n = 1'h1;
		check_pins(1'h1);
		wait_for(1'h0, 1'h0, BLANK, n);
		check_span(n + DB_OFF + 20, BLANK - 2, BLANK + 4);
		tick(100);
		button_press_n = 1'h0;
		tick(DB_ON + 100);
		check_pins(1'h0);
		button_press_n = 1'h1;
	endtask

	task automatic scn_ack();
		int n;
		boot_and_press(2'h1, 1'h1, DB_OFF + 50, n);
		check_span(n, DB_OFF, DB_OFF + 6);
		check_bit(int_wire, 1'h0);
		wait_for(1'h0, 1'h0, 600, n);
		check_span(n, 398, 412);
		check_bit(shutdown_int_pin.oe, 1'h0);
	endtask

	task automatic scn_timeout();
		int n;
		boot_and_press(2'h2, 1'h1, DB_OFF + 50, n);
		wait_for(1'h0, 1'h0, PDOWN + 50, n);
		check_span(n, PDOWN - 2, PDOWN + 4);
	endtask

	task automatic scn_kill_run();
		int n;
		tick(LOCK + 300);
		mode = 2'h1;
		power_up();
		tick(BLANK + 400);
		mode = 2'h0;
		wait_for(1'h0, 1'h0, 20, n);
		check_span(n, 1, 5);
	endtask

	task automatic scn_tied();
		int n;
		boot_and_press(2'h3, 1'h0, DB_OFF + 50, n);
		check_span(n, DB_OFF, DB_OFF + 10);
		check_pins(1'h0);
	endtask

	initial begin
		tick(12);
		nrst = 1'h1;
		check_pins(1'h0);
		check_bit(shutdown_int_pin.oe, 1'h0);
		scn_abort();
		scn_ack();
		scn_kill_run();
		scn_timeout();
		scn_tied();
		tally_and_finish();
	end

	initial begin
		tick(LIMIT);
		failures++;
		tally_and_finish();
	end
endmodule // pushbutton_power_sequencer_bench
`default_nettype wire
